// File: pkg/fbsps_pkg.sv
// Purpose: shared constants and types for the flyback switch protection sequencer
// Assumes: core_clk at 10 MHz; comparator flags arrive as asynchronous logic levels
// Notes: register map, pin indices, timing counts and state codes live here
// Contract
// R01 - no switch-on during secondary stroke
// R02 - ignore demagnetization end during suppression window
// R03 - slow demagnetization lengthens off-time same cycle; the code waits for the next oscillator rise instead
// R04 - overvoltage sample filtered against short spikes
// R05 - filtered overvoltage: switch off, latch shutdown
// R06 - latched shutdown issues no switch-on
// R07 - latch clears only below reset supply level
// R08 - overvoltage, overtemperature, lock share one latch
// R09 - overtemperature stops switching, holds latch
// R10 - lock trip stops switching, sets latch
// R11 - lock path carries no digital filter
// R12 - control level ends on-time, secondary begins
// R13 - switch-on needs oscillator, demag end, valley
// R14 - current limit blanked, then ends on-time
// R15 - on-time never shorter than blanking; a latch trip, undervoltage or disable ends it sooner
// R16 - on-time capped at 50 us, restart
// R17 - short winding trip stops, safe restart
// R18 - aux current lowers peak limit each stroke
// R19 - soft start runs until start level
// R20 - aux output on after start, off latched
// R21 - start at start level, stop below undervoltage
// R22 - gate latched, one switch-on per cycle
// R23 - inputs synchronized, intervals counted in clocks
package fbsps_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_SUPPR_NS = 1500;
    localparam int T_LEB_NS = 370;
    localparam int T_ON_MAX_NS = 50000;
    localparam logic [3:0] SUPPR_CYC = 4'((T_SUPPR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] LEB_CYC = 10'((T_LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] TON_MAX_CYC = 10'(T_ON_MAX_NS / CLK_PERIOD_NS);
    localparam logic [9:0] LEB_LAST = LEB_CYC - 10'h001;
    localparam logic [9:0] TON_LAST = TON_MAX_CYC - 10'h001;
    localparam logic [2:0] OVP_FILT_TRIP = 3'h4;

    // synchronised pin indices
    localparam int PIN_DEMAG = 0;
    localparam int PIN_OSC = 1;
    localparam int PIN_VALLEY = 2;
    localparam int PIN_CTRL = 3;
    localparam int PIN_OCP = 4;
    localparam int PIN_SWP = 5;
    localparam int PIN_OVP = 6;
    localparam int PIN_OTP = 7;
    localparam int PIN_LOCK = 8;
    localparam int PIN_START = 9;
    localparam int PIN_SUPPLY_UNDERVOLTAGE_LEVEL = 10;
    localparam int PIN_VRST = 11;
    localparam int PIN_SSLOW = 12;
    localparam int PIN_N = 13;

    // register map (byte addresses, low eight address bits decoded)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FAULT = 8'h08;
    localparam logic [7:0] ADDR_CYCLES = 8'h0C;
    localparam logic [7:0] ADDR_CORR = 8'h10;
    localparam logic CTRL_EN_RESET = 1'h1;
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_LATCH_BIT = 3;
    localparam int STAT_GATE_BIT = 4;
    localparam int STAT_AUX_BIT = 5;
    localparam int STAT_SSRUN_BIT = 6;
    localparam int STAT_SSLIM_BIT = 7;
    localparam int FLT_MAXON = 0;
    localparam int FLT_SWP = 1;
    localparam int FLT_SUPPLY_UNDERVOLTAGE_LEVEL = 2;
    localparam int FLT_OVP = 3;
    localparam int FLT_OTP = 4;
    localparam int FLT_LOCK = 5;
    localparam int FLT_N = 6;

    typedef enum logic [2:0] {
        FBSPS_ST_IDLE = 3'b000,
        FBSPS_ST_WAIT = 3'b001,
        FBSPS_ST_VALLEY = 3'b010,
        FBSPS_ST_ON = 3'b011,
        FBSPS_ST_SEC = 3'b100,
        FBSPS_ST_RESTART = 3'b101,
        FBSPS_ST_LATCH = 3'b110
    } fbsps_state_t;

endpackage

// File: design/fbsps_core.sv
// Purpose: switch cycle control and protection sequencing for a flyback controller
// Assumes: single 10 MHz clock; analog comparators deliver asynchronous flags
// Notes: AHB-Lite slave, zero-wait writes, reads take one wait state
`timescale 1ns/1ns
module fbsps_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // comparator and supply monitor flags (asynchronous)
    input wire logic aux_winding_sense,
    input wire logic osc_high,
    input wire logic valley_det,
    input wire logic ctrl_level_trip,
    input wire logic ocp_trip,
    input wire logic swp_trip,
    input wire logic overvoltage_trip,
    input wire logic otp_trip,
    input wire logic lock_trip,
    input wire logic supply_start_level,
    input wire logic supply_undervoltage_level,
    input wire logic supply_reset_level,
    input wire logic sense_below_ss,
    // measured aux current code, same clock domain
    input wire logic [7:0] aux_current_code,
    // power stage controls
    output logic gate_drive,
    output logic aux_regulated_output,
    output logic soft_start_run,
    output logic soft_start_limit,
    output logic [7:0] power_limit_correction,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);

    logic [fbsps_pkg::PIN_N-1:0] pins_in;
    logic [fbsps_pkg::PIN_N-1:0] pin_f;

    assign pins_in = {sense_below_ss, supply_reset_level, supply_undervoltage_level,
        supply_start_level, lock_trip, otp_trip, overvoltage_trip, swp_trip, ocp_trip,
        ctrl_level_trip, valley_det, osc_high, aux_winding_sense};

    // three-stage synchroniser; a change is taken once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < fbsps_pkg::PIN_N; gi++) begin : g_sync
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic f_reg;
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    f_reg <= 1'b0;
                end else begin
                    s1_reg <= pins_in[gi]; // R23
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        f_reg <= s3_reg;
                    end
                end
            end
            assign pin_f[gi] = f_reg;
        end
    endgenerate

    logic demag_f, osc_f, valley_f, ctrl_f, ocp_f, swp_f, ovp_f;
    logic otp_f, lock_f, start_f, supply_undervoltage_level_f, vrst_f, sslow_f;

    assign {sslow_f, vrst_f, supply_undervoltage_level_f, start_f, lock_f, otp_f, ovp_f, swp_f, ocp_f, ctrl_f,
        valley_f, osc_f, demag_f} = pin_f;

    fbsps_pkg::fbsps_state_t st_reg;
    fbsps_pkg::fbsps_state_t st_next;
    logic [9:0] on_cnt_reg;
    logic [3:0] sup_cnt_reg;
    logic [2:0] ovp_cnt_reg;
    logic osc_d_reg, osc_arm_reg, latch_reg, gate_reg, start_seen_reg, ctrl_en_reg;
    logic [fbsps_pkg::FLT_N-1:0] fault_reg;
    logic [fbsps_pkg::FLT_N-1:0] fault_set;
    logic [15:0] cycles_reg;
    logic [7:0] corr_reg;
    logic ovp_evt, latch_set, running, abort, blank_done, turn_on;

    // lock and otp feed the latch directly, no filtering on that path
    assign ovp_evt = (ovp_cnt_reg == fbsps_pkg::OVP_FILT_TRIP);
    assign latch_set = ovp_evt | otp_f | lock_f; // R08 R11
    assign running = st_reg inside {fbsps_pkg::FBSPS_ST_WAIT, fbsps_pkg::FBSPS_ST_VALLEY,
        fbsps_pkg::FBSPS_ST_ON, fbsps_pkg::FBSPS_ST_SEC};
    assign abort = latch_set | supply_undervoltage_level_f | !ctrl_en_reg;
    assign blank_done = (on_cnt_reg >= fbsps_pkg::LEB_LAST);
    assign turn_on = (st_next == fbsps_pkg::FBSPS_ST_ON) && (st_reg != fbsps_pkg::FBSPS_ST_ON);

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            fbsps_pkg::FBSPS_ST_IDLE: begin
                if (start_f && !supply_undervoltage_level_f && ctrl_en_reg) begin
                    st_next = fbsps_pkg::FBSPS_ST_WAIT; // R21
                end
            end
            fbsps_pkg::FBSPS_ST_WAIT: begin
                if (osc_arm_reg && !demag_f) begin
                    st_next = fbsps_pkg::FBSPS_ST_VALLEY; // R13 R01
                end
            end
            fbsps_pkg::FBSPS_ST_VALLEY: begin
                if (valley_f && !demag_f) begin
                    st_next = fbsps_pkg::FBSPS_ST_ON; // R13 R01
                end
            end
            fbsps_pkg::FBSPS_ST_ON: begin
                if (blank_done && swp_f) begin
                    st_next = fbsps_pkg::FBSPS_ST_RESTART; // R17
                end else if (on_cnt_reg == fbsps_pkg::TON_LAST) begin
                    st_next = fbsps_pkg::FBSPS_ST_RESTART; // R16
                end else if (blank_done && (ctrl_f || ocp_f)) begin
                    st_next = fbsps_pkg::FBSPS_ST_SEC; // R12 R14 R15
                end
            end
            fbsps_pkg::FBSPS_ST_SEC: begin
                if (sup_cnt_reg == fbsps_pkg::SUPPR_CYC && !demag_f) begin
                    st_next = fbsps_pkg::FBSPS_ST_WAIT; // R02
                end
            end
            fbsps_pkg::FBSPS_ST_RESTART: begin
                if (supply_undervoltage_level_f) begin
                    st_next = fbsps_pkg::FBSPS_ST_IDLE; // R17
                end
            end
            fbsps_pkg::FBSPS_ST_LATCH: begin
                if (!latch_reg) begin
                    st_next = fbsps_pkg::FBSPS_ST_IDLE; // R07
                end
            end
            default: st_next = fbsps_pkg::FBSPS_ST_IDLE;
        endcase
        if (latch_set) begin
            st_next = fbsps_pkg::FBSPS_ST_LATCH; // R05 R09 R10
        end else if (running && (supply_undervoltage_level_f || !ctrl_en_reg)) begin
            st_next = fbsps_pkg::FBSPS_ST_IDLE; // R21
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= fbsps_pkg::FBSPS_ST_IDLE;
            gate_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            gate_reg <= (st_next == fbsps_pkg::FBSPS_ST_ON); // R22 R06
        end
    end

    // on-time and suppression counters
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            on_cnt_reg <= 10'h000;
            sup_cnt_reg <= 4'h0;
        end else begin
            if (st_reg != fbsps_pkg::FBSPS_ST_ON) begin
                on_cnt_reg <= 10'h000;
            end else if (on_cnt_reg != fbsps_pkg::TON_LAST) begin
                on_cnt_reg <= on_cnt_reg + 10'h001; // R23
            end
            if (st_reg != fbsps_pkg::FBSPS_ST_SEC) begin
                sup_cnt_reg <= 4'h0;
            end else if (sup_cnt_reg != fbsps_pkg::SUPPR_CYC) begin
                sup_cnt_reg <= sup_cnt_reg + 4'h1; // R02 R23
            end
        end
    end

    // an oscillator rise during a still-running secondary stroke is not taken,
    // so a slow demagnetization pushes the switch-on out to the next period
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            osc_d_reg <= 1'b0;
            osc_arm_reg <= 1'b0;
        end else begin
            osc_d_reg <= osc_f;
            if (turn_on) begin
                osc_arm_reg <= 1'b0; // R22
            end else if (osc_f && !osc_d_reg && !demag_f) begin
                osc_arm_reg <= 1'b1; // R03 R13
            end
        end
    end

    // up/down count of overvoltage samples taken during the secondary stroke
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ovp_cnt_reg <= 3'h0;
        end else if (st_reg == fbsps_pkg::FBSPS_ST_IDLE || st_reg == fbsps_pkg::FBSPS_ST_LATCH) begin
            ovp_cnt_reg <= 3'h0;
        end else if (st_reg == fbsps_pkg::FBSPS_ST_SEC) begin
            if (ovp_f && ovp_cnt_reg != fbsps_pkg::OVP_FILT_TRIP) begin
                ovp_cnt_reg <= ovp_cnt_reg + 3'h1; // R04
            end else if (!ovp_f && ovp_cnt_reg != 3'h0) begin
                ovp_cnt_reg <= ovp_cnt_reg - 3'h1; // R04
            end
        end
    end

    // shutdown latch; a new trip beats the supply-reset clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            latch_reg <= 1'b0;
        end else if (latch_set) begin
            latch_reg <= 1'b1; // R05 R08 R09 R10
        end else if (vrst_f) begin
            latch_reg <= 1'b0; // R07
        end
    end

    // start tracking, soft start and aux output
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            start_seen_reg <= 1'b0;
            soft_start_run <= 1'b0;
            soft_start_limit <= 1'b0;
            aux_regulated_output <= 1'b0;
        end else begin
            if (start_f) begin
                start_seen_reg <= 1'b1;
            end else if (vrst_f || supply_undervoltage_level_f) begin
                start_seen_reg <= 1'b0;
            end
            soft_start_run <= !start_f && !start_seen_reg; // R19
            soft_start_limit <= !start_f && !start_seen_reg && !sslow_f; // R19
            aux_regulated_output <= start_seen_reg && !latch_reg && !latch_set; // R20
        end
    end

    // peak-limit correction captured while the primary stroke runs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            corr_reg <= 8'h00;
            cycles_reg <= 16'h0000;
        end else begin
            if (st_reg == fbsps_pkg::FBSPS_ST_ON) begin
                corr_reg <= aux_current_code; // R18
            end
            if (turn_on) begin
                cycles_reg <= cycles_reg + 16'h0001;
            end
        end
    end

    assign gate_drive = gate_reg;
    assign power_limit_correction = corr_reg;

    assign fault_set[fbsps_pkg::FLT_MAXON] = (st_reg == fbsps_pkg::FBSPS_ST_ON)
        && (on_cnt_reg == fbsps_pkg::TON_LAST);
    assign fault_set[fbsps_pkg::FLT_SWP] = (st_reg == fbsps_pkg::FBSPS_ST_ON) && blank_done && swp_f;
    assign fault_set[fbsps_pkg::FLT_SUPPLY_UNDERVOLTAGE_LEVEL] = running && supply_undervoltage_level_f;
    assign fault_set[fbsps_pkg::FLT_OVP] = ovp_evt;
    assign fault_set[fbsps_pkg::FLT_OTP] = otp_f;
    assign fault_set[fbsps_pkg::FLT_LOCK] = lock_f;

    // AHB-Lite slave
    logic wr_pend_reg, rd_wait_reg, take, fault_wr;
    logic [7:0] wr_addr_reg, rd_addr_reg;
    logic [31:0] rd_mux;

    assign take = hsel && hready && htrans[1];
    assign fault_wr = wr_pend_reg && (wr_addr_reg == fbsps_pkg::ADDR_FAULT);
    assign hresp = 1'b0;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rd_wait_reg <= 1'b0;
            rd_addr_reg <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= take && hwrite;
            if (take) begin
                wr_addr_reg <= haddr[7:0];
                rd_addr_reg <= haddr[7:0];
            end
            // one wait state lets a read see a write committed just before it
            rd_wait_reg <= take && !hwrite;
            hreadyout <= !(take && !hwrite);
            if (rd_wait_reg) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (rd_addr_reg)
            fbsps_pkg::ADDR_CTRL: rd_mux[fbsps_pkg::CTRL_EN_BIT] = ctrl_en_reg;
            fbsps_pkg::ADDR_STATUS: begin
                rd_mux[fbsps_pkg::STAT_STATE_LSB +: 3] = st_reg;
                rd_mux[fbsps_pkg::STAT_LATCH_BIT] = latch_reg;
                rd_mux[fbsps_pkg::STAT_GATE_BIT] = gate_reg;
                rd_mux[fbsps_pkg::STAT_AUX_BIT] = aux_regulated_output;
                rd_mux[fbsps_pkg::STAT_SSRUN_BIT] = soft_start_run;
                rd_mux[fbsps_pkg::STAT_SSLIM_BIT] = soft_start_limit;
            end
            fbsps_pkg::ADDR_FAULT: rd_mux[fbsps_pkg::FLT_N-1:0] = fault_reg;
            fbsps_pkg::ADDR_CYCLES: rd_mux[15:0] = cycles_reg;
            fbsps_pkg::ADDR_CORR: rd_mux[7:0] = corr_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_en_reg <= fbsps_pkg::CTRL_EN_RESET;
        end else if (wr_pend_reg && wr_addr_reg == fbsps_pkg::ADDR_CTRL) begin
            ctrl_en_reg <= hwdata[fbsps_pkg::CTRL_EN_BIT];
        end
    end

    // sticky fault causes, write one to clear, a new event wins over the clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fault_reg <= '0;
        end else if (fault_wr) begin
            fault_reg <= (fault_reg & ~hwdata[fbsps_pkg::FLT_N-1:0]) | fault_set;
        end else begin
            fault_reg <= fault_reg | fault_set;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence seq_turn_on;
        $rose(gate_reg);
    endsequence

    sequence seq_valley_ready;
        $past(st_reg == fbsps_pkg::FBSPS_ST_VALLEY) && $past(!demag_f) && $past(valley_f);
    endsequence

    AST_NO_ON_IN_DEMAG: assert property (seq_turn_on |-> seq_valley_ready) // R01
        else $error("switch-on while secondary stroke active");
    AST_SUPPRESS: assert property ((st_reg == fbsps_pkg::FBSPS_ST_SEC)
        && (sup_cnt_reg < fbsps_pkg::SUPPR_CYC) && !abort |=>
        (st_reg == fbsps_pkg::FBSPS_ST_SEC)) // R02
        else $error("demag end taken inside suppression");
    AST_OVP_FILTER: assert property ($rose(ovp_evt) |->
        $past(ovp_f) && $past(ovp_f, 2)) // R04
        else $error("overvoltage tripped on a short spike");
    AST_LATCH_OFF: assert property (latch_set |=> !gate_reg && latch_reg
        && (st_reg == fbsps_pkg::FBSPS_ST_LATCH)) // R05
        else $error("latching fault did not stop switching");
    AST_LATCH_NO_ON: assert property (latch_reg |-> !gate_reg) // R06
        else $error("gate on during latched shutdown");
    AST_LATCH_HOLD: assert property (latch_reg && !vrst_f |=> latch_reg) // R07
        else $error("latch cleared without supply reset");
    AST_LOCK_DIRECT: assert property ($rose(lock_f) |=> latch_reg [*2]) // R10
        else $error("lock trip did not set latch at once");
    AST_CTRL_END: assert property ((st_reg == fbsps_pkg::FBSPS_ST_ON) && blank_done && ctrl_f
        && !swp_f && (on_cnt_reg != fbsps_pkg::TON_LAST) && !abort |=>
        !gate_reg && (st_reg == fbsps_pkg::FBSPS_ST_SEC)) // R12
        else $error("control level did not end on-time");
    AST_MIN_ON: assert property (seq_turn_on ##0 !abort [*4] |-> gate_reg) // R15
        else $error("on-time shorter than blanking");
    AST_MAX_ON: assert property ((st_reg == fbsps_pkg::FBSPS_ST_ON)
        && (on_cnt_reg == fbsps_pkg::TON_LAST) && !abort |=>
        (st_reg == fbsps_pkg::FBSPS_ST_RESTART) ##1 !gate_reg) // R16
        else $error("maximum on-time not enforced");
    AST_SWP_STOP: assert property ((st_reg == fbsps_pkg::FBSPS_ST_ON) && blank_done && swp_f
        && !abort |=> (st_reg == fbsps_pkg::FBSPS_ST_RESTART)) // R17
        else $error("short winding did not stop switching");
    AST_AUX_OFF: assert property (latch_reg |=> !aux_regulated_output) // R20
        else $error("aux output on during latched shutdown");
    AST_ONE_ON: assert property (seq_turn_on |-> !osc_arm_reg) // R22
        else $error("second switch-on armed in same cycle");

endmodule

// File: dv/fbsps_stage_model.sv
// Purpose: behavioural flyback power stage answering the gate with comparator flags
// Assumes: gate_drive is registered on core_clk
// Notes: valley shows only once the secondary stroke is over, as a real drain would
`timescale 1ns/1ns
module fbsps_stage_model (
    // clock
    input wire logic core_clk,
    // gate and stage behaviour
    input wire logic gate_drive,
    input wire logic [9:0] on_len,
    input wire logic [7:0] demag_len,
    // comparator flags
    output logic aux_winding_sense,
    output logic ctrl_level_trip,
    output logic valley_det
);
    logic [9:0] on_cnt = 10'h000;
    logic [7:0] sec_cnt = 8'h00;

    always @(posedge core_clk) begin
        on_cnt <= gate_drive ? on_cnt + 10'h001 : 10'h000;
        if (gate_drive) begin
            sec_cnt <= demag_len;
        end else if (sec_cnt != 8'h00) begin
            sec_cnt <= sec_cnt - 8'h01;
        end
    end
    // a long on_len never reaches the control level, which forces the on-time cap
    assign ctrl_level_trip = gate_drive && (on_cnt >= on_len);
    assign aux_winding_sense = !gate_drive && (sec_cnt != 8'h00);
    assign valley_det = !gate_drive && !aux_winding_sense;
endmodule

// File: dv/flyback_switch_protection_sequencer_tb.sv
// Purpose: self-checking bench for the switch protection sequencer
// Assumes: stage model answers the gate; bench drives supply, fault flags and bus
// Notes: outputs sampled at the falling edge, away from the launching edge
`timescale 1ns/1ns
module flyback_switch_protection_sequencer_tb;
    localparam int FB[4] = '{fbsps_pkg::FLT_LOCK, fbsps_pkg::FLT_OTP, fbsps_pkg::FLT_OVP,
        fbsps_pkg::FLT_SWP};
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic osc_high = 1'b0;
    logic [5:0] osc_cnt = 6'h00;
    logic [3:0] flt_in = 4'h0;
    logic supply_start_level = 1'b0;
    logic supply_undervoltage_level = 1'b0;
    logic supply_reset_level = 1'b0;
    logic sense_below_ss = 1'b1;
    logic [7:0] aux_current_code = 8'h5A;
    logic [9:0] on_len = 10'h008;
    logic [7:0] demag_len = 8'h14;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic aux_winding_sense, valley_det, ctrl_level_trip, gate_drive, aux_regulated_output;
    logic soft_start_run, soft_start_limit, hreadyout, hresp;
    logic [7:0] power_limit_correction;
    logic [31:0] hrdata;
    int fail_count = 0;
    int comparisons = 0;

    fbsps_core dut_u (
        .core_clk, .rstn, .aux_winding_sense, .osc_high, .valley_det, .ctrl_level_trip,
        .ocp_trip(1'b0), .swp_trip(flt_in[3]), .overvoltage_trip(flt_in[2]),
        .otp_trip(flt_in[1]), .lock_trip(flt_in[0]), .supply_start_level,
        .supply_undervoltage_level, .supply_reset_level, .sense_below_ss, .aux_current_code,
        .gate_drive, .aux_regulated_output, .soft_start_run, .soft_start_limit,
        .power_limit_correction, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata
    );
    fbsps_stage_model model_u (
        .core_clk, .gate_drive, .on_len, .demag_len, .aux_winding_sense, .ctrl_level_trip,
        .valley_det
    );

    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        osc_cnt <= osc_cnt + 6'h01;
        osc_high <= osc_cnt[5];
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t %s", $time, m);
        end
    endtask
    // hready seen at the falling edge is what the next rising edge samples
    task bus_wait(output logic [31:0] rd);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            rd = hrdata;
            n++;
            @(posedge core_clk);
        end while (hreadyout !== 1'b1 && n < 20);
    endtask
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        htrans <= 2'b10;
        haddr <= 32'(a);
        hwrite <= wr;
        bus_wait(rd);
        htrans <= 2'b00;
        hwdata <= wd;
        bus_wait(rd);
    endtask
    task wait_gate(input logic lvl, input int lim, output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (gate_drive !== lvl && n < lim);
    endtask
    task supply(input logic below_reset);
        @(posedge core_clk);
        supply_undervoltage_level <= 1'b1;
        supply_start_level <= 1'b0;
        supply_reset_level <= below_reset;
        repeat (10) @(posedge core_clk);
        supply_undervoltage_level <= 1'b0;
        supply_start_level <= 1'b1;
        supply_reset_level <= 1'b0;
    endtask

    task t_reset();
        logic [31:0] d;
        ahb(1'b0, fbsps_pkg::ADDR_CTRL, 32'h0000_0000, d);
        chk(d, 32'h0000_0001, "enable reset");
        ahb(1'b0, 8'h40, 32'h0000_0000, d);
        chk(d, 32'h0000_0000, "unmapped read");
        chk({soft_start_run, aux_regulated_output, gate_drive}, 3'b100, "before start");
        @(posedge core_clk);
        sense_below_ss <= 1'b0;
        repeat (6) @(negedge core_clk);
        chk(soft_start_limit, 1'b1, "soft start limiting");
        @(posedge core_clk);
        supply_start_level <= 1'b1;
        repeat (7) @(negedge core_clk);
        chk({soft_start_run, aux_regulated_output}, 2'b01, "after start");
        $display("t_reset done");
    endtask
    task t_cycle();
        int n, on_n, off_n;
        logic [31:0] d;
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            on_len <= (i == 0) ? 10'h001 : 10'h01E;
            demag_len <= (i == 0) ? 8'h14 : 8'h28;
            wait_gate(1'b1, 3000, n);
            wait_gate(1'b0, 3000, n);
            wait_gate(1'b1, 3000, n);
            chk(aux_winding_sense, 1'b0, "switch-on in secondary");
            wait_gate(1'b0, 3000, on_n);
            wait_gate(1'b1, 3000, off_n);
            chk(on_n >= fbsps_pkg::LEB_CYC, 1'b1, "short on-time");
            chk(i == 0 || (on_n >= 30 && on_n <= 40), 1'b1, "on-time vs control");
            chk(off_n >= 20 * (i + 1), 1'b1, "off-time");
        end
        ahb(1'b0, fbsps_pkg::ADDR_CORR, 32'h0000_0000, d);
        chk(d, 32'h0000_005A, "correction code");
        $display("t_cycle done");
    endtask
    task t_maxon();
        int n;
        logic [31:0] d;
        wait_gate(1'b0, 3000, n);
        @(posedge core_clk);
        on_len <= 10'h3FF;
        wait_gate(1'b1, 3000, n);
        wait_gate(1'b0, 600, n);
        chk(n, fbsps_pkg::TON_MAX_CYC, "on-time cap");
        ahb(1'b0, fbsps_pkg::ADDR_STATUS, 32'h0000_0000, d);
        chk(d[2:0], fbsps_pkg::FBSPS_ST_RESTART, "cap state");
        ahb(1'b0, fbsps_pkg::ADDR_FAULT, 32'h0000_0000, d);
        chk(d[fbsps_pkg::FLT_MAXON], 1'b1, "cap fault flag");
        on_len <= 10'h008;
        supply(1'b0);
        wait_gate(1'b1, 3000, n);
        chk(gate_drive, 1'b1, "supply_undervoltage_level restart");
        $display("t_maxon done");
    endtask
    task t_faults();
        int n;
        logic [31:0] d;
        for (int i = 0; i < 4; i++) begin
            wait_gate(1'b1, 3000, n);
            @(posedge core_clk);
            flt_in[i] <= 1'b1;
            repeat (i < 2 ? 2 : 200) @(posedge core_clk);
            flt_in[i] <= 1'b0;
            repeat (8) @(negedge core_clk);
            chk(gate_drive, 1'b0, "gate on");
            chk(i == 3 || aux_regulated_output === 1'b0, 1'b1, "aux on");
            ahb(1'b0, fbsps_pkg::ADDR_STATUS, 32'h0000_0000, d);
            chk(d[fbsps_pkg::STAT_LATCH_BIT], i < 3, "latch state");
            ahb(1'b0, fbsps_pkg::ADDR_FAULT, 32'h0000_0000, d);
            chk(d[FB[i]], 1'b1, "fault flag");
            ahb(1'b1, fbsps_pkg::ADDR_FAULT, 32'hFFFF_FFFF, d);
            supply(1'b0);
            wait_gate(1'b1, 300, n);
            chk(gate_drive === 1'b1, i == 3, "supply cycle");
            if (i < 3) begin
                supply(1'b1);
                wait_gate(1'b1, 3000, n);
                chk(gate_drive, 1'b1, "latch reset");
            end
        end
        $display("t_faults done");
    endtask

    task test_done();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_cycle();
        t_maxon();
        t_faults();
        test_done();
    end
    initial begin
        #4000000;
        fail_count++;
        $display("mismatch t=%0t watchdog expired", $time);
        test_done();
    end
endmodule
